// >>> rtl/scu_sim_uart.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: internal clock rate is fi over 16(n+1)
// RULE2: external pin clock rate is fext over 16(n+1)
// RULE3: transmit starts with enable set, buffer full
// RULE4: receive starts with enable set, start bit
// RULE5: source select 1 raises tx irq at end
// RULE6: rx irq when character moves to buffer
// RULE7: overrun flagged at bit before stop
// RULE8: framing error when stop bit missing
// RULE9: parity error drives serial output low
// RULE10: card pulls line low; software samples input
// RULE11: error sum set on any error
// RULE12: overrun leaves buffer, rx irq untouched
// RULE13: direct and inverse character formats supported
// RULE14: serial output is open drain
// RULE15: buffer read clears parity flag, releases line
// RULE16: tx finished irq right after stop bit
// RULE17: software picks format via three select bits
// RULE18: inverse is msb first, inverted levels
module scu_sim_uart (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Serial pins.
  input wire logic ext_clock_pin,
  input wire logic serial_in_pin,
  output logic serial_out_o,
  output logic serial_out_oe,
  // Interrupt.
  output logic irq
);
  import scu_pkg::*;

  // Picks the next bit to shift, honouring the bit order.
  function automatic logic pick_bit(input logic msb_first, input logic [7:0] v);
    pick_bit = msb_first ? v[7] : v[0];
  endfunction

  // Shifts one bit in or out in the configured direction.
  function automatic logic [7:0] shift8(input logic msb_first, input logic [7:0] v,
                                        input logic b);
    shift8 = msb_first ? {v[6:0], b} : {b, v[7:1]};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ext_s_q, ext_s_d, rxp_s_q, rxp_s_d;
  logic ext_lvl_q, ext_lvl_d, rx_lvl_q, rx_lvl_d, ext_rise;

  // A level is accepted only once the second and third stages agree.
  always_comb begin
    ext_s_d = {ext_s_q[1:0], ext_clock_pin};
    rxp_s_d = {rxp_s_q[1:0], serial_in_pin};
    ext_lvl_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_lvl_q;
    rx_lvl_d = (rxp_s_q[1] == rxp_s_q[2]) ? rxp_s_q[2] : rx_lvl_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_s_q <= 3'h0;
      rxp_s_q <= 3'h7;
      ext_lvl_q <= 1'b0;
      rx_lvl_q <= 1'b1;
    end else if (ce) begin
      ext_s_q <= ext_s_d;
      rxp_s_q <= rxp_s_d;
      ext_lvl_q <= ext_lvl_d;
      rx_lvl_q <= rx_lvl_d;
    end
  end

  assign ext_rise = ext_lvl_d & ~ext_lvl_q;

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  logic [5:0] mode_q, mode_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] baud_q, baud_d, txbuf_q, txbuf_d;
  logic [2:0] imask_q, imask_d;
  logic wr_tx, rd_rx;

  assign wr_tx = wr && (addr == SCU_OFF_TXBUF);
  assign rd_rx = rd && (addr == SCU_OFF_RXBUF);

  // Plain storage; unmapped writes are dropped.
  always_comb begin
    mode_d = mode_q;
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    txbuf_d = txbuf_q;
    imask_d = imask_q;
    if (wr) begin
      if (addr == SCU_OFF_TXBUF) begin
        txbuf_d = wdata[7:0];
      end else if (addr == SCU_OFF_BAUD) begin
        baud_d = wdata[7:0];
      end else if (addr == SCU_OFF_MODE) begin
        mode_d = wdata[5:0];
      end else if (addr == SCU_OFF_CTRL) begin
        ctrl_d = wdata[2:0];
      end else if (addr == SCU_OFF_IRQ_MASK) begin
        imask_d = wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= SCU_MODE_RST;
      ctrl_q <= SCU_CTRL_RST;
      baud_q <= SCU_BAUD_RST;
      txbuf_q <= 8'h00;
      imask_q <= 3'h0;
    end else if (ce) begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      txbuf_q <= txbuf_d;
      imask_q <= imask_d;
    end
  end

  logic msb_first, inv, par_odd;
  assign msb_first = mode_q[SCU_MD_ORDER]; // RULE18
  assign inv = mode_q[SCU_MD_INV]; // RULE13
  assign par_odd = ~mode_q[SCU_MD_PAR];

  // ----------------------------------------------------------------
  // Bit clock: prescaler, source select and 16x divider
  // ----------------------------------------------------------------
  logic [4:0] pre_q, pre_d;
  logic [7:0] bdiv_q, bdiv_d;
  logic src_pulse, tick;

  // The divider reloads n, so one tick comes every n+1 source pulses.
  always_comb begin
    pre_d = pre_q + 5'h01;
    case (mode_q[SCU_MD_PRE +: 2])
      2'h0: src_pulse = 1'b1;
      2'h1: src_pulse = pre_q[0];
      2'h2: src_pulse = (pre_q[2:0] == 3'h7);
      default: src_pulse = (pre_q == SCU_PRE_ALL);
    endcase
    if (mode_q[SCU_MD_CKSRC]) begin
      src_pulse = ext_rise; // RULE2
    end
    bdiv_d = bdiv_q;
    tick = 1'b0;
    if (src_pulse) begin
      if (bdiv_q == 8'h00) begin
        bdiv_d = baud_q; // RULE1
        tick = 1'b1;
      end else begin
        bdiv_d = bdiv_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= 5'h00;
      bdiv_q <= 8'h00;
    end else if (ce) begin
      pre_q <= pre_d;
      bdiv_q <= bdiv_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  scu_state_t tx_st_q, tx_st_d;
  logic [3:0] tx_ph_q, tx_ph_d;
  logic [2:0] tx_bit_q, tx_bit_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic tx_par_q, tx_par_d, tx_line_q, tx_line_d, tx_empty_q, tx_empty_d;
  logic tx_load, tx_done, tx_end_bit;

  assign tx_end_bit = tick && (tx_ph_q == SCU_OVS_LAST);

  // Each bit lasts sixteen ticks; parity is kept over line levels.
  always_comb begin
    tx_st_d = tx_st_q;
    tx_ph_d = tick ? tx_ph_q + 4'h1 : tx_ph_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_par_d = tx_par_q;
    tx_line_d = tx_line_q;
    tx_load = 1'b0;
    tx_done = 1'b0;
    case (tx_st_q)
      SCU_IDLE: begin
        tx_ph_d = 4'h0;
        tx_line_d = 1'b1;
        if (ctrl_q[SCU_CT_TXEN] && !tx_empty_q && tick) begin // RULE3
          tx_load = 1'b1;
          tx_sh_d = txbuf_q;
          tx_st_d = SCU_START;
          tx_line_d = 1'b0;
          tx_bit_d = 3'h0;
          tx_par_d = par_odd;
        end
      end
      SCU_START: begin
        if (tx_end_bit) begin
          tx_st_d = SCU_DATA;
          tx_line_d = pick_bit(msb_first, tx_sh_q) ^ inv; // RULE18
        end
      end
      SCU_DATA: begin
        if (tx_end_bit) begin
          tx_par_d = tx_par_q ^ tx_line_q;
          tx_sh_d = shift8(msb_first, tx_sh_q, 1'b0);
          tx_bit_d = tx_bit_q + 3'h1;
          tx_line_d = pick_bit(msb_first, tx_sh_d) ^ inv;
          if (tx_bit_q == SCU_LAST_BIT) begin
            tx_st_d = SCU_PAR;
            tx_line_d = tx_par_q ^ tx_line_q;
          end
        end
      end
      SCU_PAR: begin
        if (tx_end_bit) begin
          tx_st_d = SCU_STOP;
          tx_line_d = 1'b1;
        end
      end
      default: begin
        if (tx_end_bit) begin
          tx_st_d = SCU_IDLE;
          tx_done = 1'b1; // RULE16
        end
      end
    endcase
    tx_empty_d = tx_empty_q;
    if (tx_load) begin
      tx_empty_d = 1'b1;
    end else if (wr_tx) begin
      tx_empty_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_q <= SCU_IDLE;
      tx_ph_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_empty_q <= 1'b1;
    end else if (ce) begin
      tx_st_q <= tx_st_d;
      tx_ph_q <= tx_ph_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_par_q <= tx_par_d;
      tx_line_q <= tx_line_d;
      tx_empty_q <= tx_empty_d;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  scu_state_t rx_st_q, rx_st_d;
  logic [3:0] rx_ph_q, rx_ph_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rxbuf_q, rxbuf_d;
  logic rx_par_q, rx_par_d, rx_full_q, rx_full_d, err_drv_q, err_drv_d;
  logic ovr_q, ovr_d, frm_q, frm_d, perr_q, perr_d, ovr_pend_q, ovr_pend_d;
  logic rx_done, rx_err_ev, rx_smp;

  assign rx_smp = tick && (rx_ph_q == SCU_OVS_LAST);

  // Bits are sampled at mid cell; the start bit is checked at tick 8.
  always_comb begin
    rx_st_d = rx_st_q;
    rx_ph_d = tick ? rx_ph_q + 4'h1 : rx_ph_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_par_d = rx_par_q;
    ovr_pend_d = ovr_pend_q;
    rxbuf_d = rxbuf_q;
    rx_done = 1'b0;
    rx_err_ev = 1'b0;
    ovr_d = ovr_q;
    frm_d = frm_q;
    perr_d = perr_q;
    err_drv_d = err_drv_q;
    rx_full_d = rx_full_q;
    if (rd_rx) begin
      rx_full_d = 1'b0;
      ovr_d = 1'b0;
      frm_d = 1'b0;
      perr_d = 1'b0; // RULE15
      err_drv_d = 1'b0; // RULE15
    end
    case (rx_st_q)
      SCU_IDLE: begin
        rx_ph_d = 4'h0;
        if (ctrl_q[SCU_CT_RXEN] && !rx_lvl_q) begin // RULE4
          rx_st_d = SCU_START;
        end
      end
      SCU_START: begin
        if (tick && rx_ph_q == SCU_OVS_MID) begin
          rx_ph_d = 4'h0;
          rx_bit_d = 3'h0;
          rx_par_d = par_odd;
          rx_st_d = rx_lvl_q ? SCU_IDLE : SCU_DATA;
        end
      end
      SCU_DATA: begin
        if (rx_smp) begin
          rx_sh_d = shift8(msb_first, rx_sh_q, rx_lvl_q ^ inv); // RULE18
          rx_par_d = rx_par_q ^ rx_lvl_q;
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == SCU_LAST_BIT) begin
            rx_st_d = SCU_PAR;
          end
        end
      end
      SCU_PAR: begin
        if (rx_smp) begin
          rx_par_d = rx_par_q ^ rx_lvl_q;
          ovr_pend_d = rx_full_q && !rd_rx; // RULE7
          rx_st_d = SCU_STOP;
        end
      end
      default: begin
        if (rx_smp) begin
          rx_st_d = SCU_IDLE;
          if (ovr_pend_q) begin
            ovr_d = 1'b1; // RULE12
            rx_err_ev = 1'b1;
          end else begin
            rxbuf_d = rx_sh_q;
            rx_full_d = 1'b1;
            rx_done = 1'b1; // RULE6
          end
          if (!rx_lvl_q) begin
            frm_d = 1'b1; // RULE8
            rx_err_ev = 1'b1;
          end
          if (rx_par_q) begin
            perr_d = 1'b1;
            err_drv_d = 1'b1; // RULE9
            rx_err_ev = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_st_q <= SCU_IDLE;
      rx_ph_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rx_full_q <= 1'b0;
      ovr_pend_q <= 1'b0;
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      perr_q <= 1'b0;
      err_drv_q <= 1'b0;
    end else if (ce) begin
      rx_st_q <= rx_st_d;
      rx_ph_q <= rx_ph_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_par_q <= rx_par_d;
      rxbuf_q <= rxbuf_d;
      rx_full_q <= rx_full_d;
      ovr_pend_q <= ovr_pend_d;
      ovr_q <= ovr_d;
      frm_q <= frm_d;
      perr_q <= perr_d;
      err_drv_q <= err_drv_d;
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high.
  assign serial_out_o = 1'b0; // RULE14
  assign serial_out_oe = ~tx_line_q | err_drv_q; // RULE9

  // ----------------------------------------------------------------
  // Interrupt status and read data
  // ----------------------------------------------------------------
  logic [2:0] istat_q, istat_d, iset;
  logic [31:0] rdata_q, rdata_d;
  logic err_sum;

  assign err_sum = ovr_q | frm_q | perr_q; // RULE11

  // A set in the same cycle as a write-one clear wins.
  always_comb begin
    iset = 3'h0;
    iset[SCU_IS_TX] = ctrl_q[SCU_CT_IRS] ? tx_done : tx_load; // RULE5
    iset[SCU_IS_RX] = rx_done;
    iset[SCU_IS_ERR] = rx_err_ev;
    istat_d = istat_q;
    if (wr && addr == SCU_OFF_IRQ_STAT) begin
      istat_d = istat_q & ~wdata[2:0];
    end
    istat_d = istat_d | iset;
    rdata_d = 32'h0000_0000;
    if (rd) begin
      if (addr == SCU_OFF_RXBUF) begin
        rdata_d[7:0] = rxbuf_q;
        rdata_d[SCU_RB_OVR] = ovr_q;
        rdata_d[SCU_RB_FRM] = frm_q;
        rdata_d[SCU_RB_PAR] = perr_q;
        rdata_d[SCU_RB_SUM] = err_sum;
      end else if (addr == SCU_OFF_BAUD) begin
        rdata_d[7:0] = baud_q;
      end else if (addr == SCU_OFF_MODE) begin
        rdata_d[5:0] = mode_q;
      end else if (addr == SCU_OFF_CTRL) begin
        rdata_d[2:0] = ctrl_q;
        rdata_d[SCU_CT_TXEMPTY] = tx_empty_q;
        rdata_d[SCU_CT_TXIDLE] = (tx_st_q == SCU_IDLE);
        rdata_d[SCU_CT_RXFULL] = rx_full_q;
      end else if (addr == SCU_OFF_IRQ_STAT) begin
        rdata_d[2:0] = istat_q;
      end else if (addr == SCU_OFF_IRQ_MASK) begin
        rdata_d[2:0] = imask_q;
      end else if (addr == SCU_OFF_LINE) begin
        rdata_d[0] = rx_lvl_q; // RULE10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_q <= 3'h0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      istat_q <= istat_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rx_stop_done;
    ce && rx_st_q == SCU_STOP && rx_smp && !ovr_pend_q;
  endsequence

  AST_TX_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    ce && tx_st_q == SCU_IDLE && tx_st_d == SCU_START |->
      ctrl_q[SCU_CT_TXEN] && !tx_empty_q)
    else $error("transmit started without enable or data");
  AST_RX_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    ce && rx_st_q == SCU_IDLE && rx_st_d == SCU_START |-> ctrl_q[SCU_CT_RXEN])
    else $error("receive started while disabled");
  AST_TX_IRQ_END: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    ce && ctrl_q[SCU_CT_IRS] && tx_st_q == SCU_STOP && tx_end_bit |=>
      istat_q[SCU_IS_TX] && tx_st_q == SCU_IDLE)
    else $error("tx finished irq missing");
  AST_RX_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    s_rx_stop_done |=> istat_q[SCU_IS_RX] && rx_full_q && rxbuf_q == $past(rx_sh_q))
    else $error("received byte not moved to buffer");
  AST_OVR_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    ce && rx_st_q == SCU_STOP && rx_smp && ovr_pend_q |=>
      ovr_q && $stable(rxbuf_q))
    else $error("overrun changed the buffer");
  AST_PERR_LOW: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    perr_q && err_drv_q |-> serial_out_oe && !serial_out_o)
    else $error("parity error not driven low");
  AST_PERR_CLR: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    ce && rd_rx && !(rx_st_q == SCU_STOP && rx_smp) |=> !perr_q && !err_drv_q)
    else $error("buffer read did not clear parity error");
  AST_SUM: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    ce && rd && addr == SCU_OFF_RXBUF && (ovr_q || frm_q || perr_q) |=>
      rdata[SCU_RB_SUM])
    else $error("error sum missing");
  AST_DIV: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    ce && tick |=> bdiv_q == baud_q || !$stable(baud_q))
    else $error("divider did not reload");
  AST_READ_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !rd |=> rdata == 32'h0000_0000)
    else $error("read data held past its cycle");

endmodule

// >>> rtl/scu_pkg.sv
package scu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] SCU_OFF_TXBUF = 8'h00;
  localparam logic [7:0] SCU_OFF_RXBUF = 8'h04;
  localparam logic [7:0] SCU_OFF_BAUD = 8'h08;
  localparam logic [7:0] SCU_OFF_MODE = 8'h0C;
  localparam logic [7:0] SCU_OFF_CTRL = 8'h10;
  localparam logic [7:0] SCU_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] SCU_OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] SCU_OFF_LINE = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCU_MD_CKSRC = 0;
  localparam int SCU_MD_PRE = 1;
  localparam int SCU_MD_PAR = 3;
  localparam int SCU_MD_ORDER = 4;
  localparam int SCU_MD_INV = 5;
  localparam int SCU_CT_TXEN = 0;
  localparam int SCU_CT_RXEN = 1;
  localparam int SCU_CT_IRS = 2;
  localparam int SCU_CT_TXEMPTY = 3;
  localparam int SCU_CT_TXIDLE = 4;
  localparam int SCU_CT_RXFULL = 5;
  localparam int SCU_RB_OVR = 12;
  localparam int SCU_RB_FRM = 13;
  localparam int SCU_RB_PAR = 14;
  localparam int SCU_RB_SUM = 15;
  localparam int SCU_IS_TX = 0;
  localparam int SCU_IS_RX = 1;
  localparam int SCU_IS_ERR = 2;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [5:0] SCU_MODE_RST = 6'h08;
  localparam logic [2:0] SCU_CTRL_RST = 3'h0;
  localparam logic [7:0] SCU_BAUD_RST = 8'h00;
  localparam logic [4:0] SCU_PRE_ALL = 5'h1F;
  localparam logic [3:0] SCU_OVS_LAST = 4'hF;
  localparam logic [3:0] SCU_OVS_MID = 4'h7;
  localparam logic [2:0] SCU_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    SCU_IDLE = 3'b000,
    SCU_START = 3'b001,
    SCU_DATA = 3'b011,
    SCU_PAR = 3'b010,
    SCU_STOP = 3'b110
  } scu_state_t;

endpackage

// >>> bench/scu_card.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Smart card on the shared pulled-up line
// ------------------------------------------------------------
module scu_card (
  // Clock.
  input wire logic clk,
  // Shared line, and the card's pull-down enable.
  input wire logic line,
  output logic card_oe
);
  int bit_clks = 16;

  // The card only ever pulls low; released, the pull-up wins.
  initial card_oe = 1'b0;

  // Line levels in send order, parity in bit 8.
  function automatic logic [8:0] enc(input logic [7:0] d, input logic inv);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) b[i] = inv ? ~d[7 - i] : d[i];
    return {inv ? ~^b : ^b, b};
  endfunction

  // A bad stop bit is low only long enough to be sampled, so no false start follows.
  task automatic send(input logic [7:0] d, input logic inv, input logic bad_par,
                      input logic bad_stop);
    logic [8:0] f;
    f = enc(d, inv);
    f[8] = f[8] ^ bad_par;
    @(posedge clk);
    card_oe <= 1'b1;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      card_oe <= ~f[i];
      repeat (bit_clks) @(posedge clk);
    end
    card_oe <= bad_stop;
    repeat (bit_clks * 3 / 4) @(posedge clk);
    card_oe <= 1'b0;
    repeat (bit_clks * 2) @(posedge clk);
  endtask

  // Samples mid-bit; with nak set it holds the line low over the stop bit.
  task automatic recv(output logic [7:0] d, input logic inv, input logic nak);
    logic [8:0] f;
    while (line !== 1'b0) @(posedge clk);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_clks) @(posedge clk);
      f[i] = line;
    end
    for (int i = 0; i < 8; i++) d[inv ? 7 - i : i] = f[i] ^ inv;
    if (nak) begin
      repeat (bit_clks / 2) @(posedge clk);
      card_oe <= 1'b1;
      repeat (bit_clks * 2) @(posedge clk);
      card_oe <= 1'b0;
    end
  endtask
endmodule

// >>> bench/scu_sim_uart_tb.sv
`timescale 1ns/1ps
module scu_sim_uart_tb;
  import scu_pkg::*;

  typedef struct {logic [7:0] d; logic inv; logic [1:0] pre; logic [7:0] n; int bits;} scu_row_t;

  logic clk, rst_n, ce, wr, rd, ext_clock_pin, serial_out_o, serial_out_oe, irq, card_oe;
  logic line;
  logic [1:0] ext_cnt = 2'h0;
  logic [7:0] addr, got, mode;
  logic [31:0] wdata, rdata, v;
  int n_errors = 0;
  int samples_checked = 0;
  // Bit period is 16 * prescale * (n + 1) clocks.
  scu_row_t rows [5] = '{'{8'h3C, 1'b0, 2'h0, 8'h00, 16}, '{8'hA5, 1'b1, 2'h0, 8'h02, 48},
    '{8'h01, 1'b0, 2'h1, 8'h00, 32}, '{8'hFE, 1'b1, 2'h2, 8'h00, 128},
    '{8'h80, 1'b0, 2'h3, 8'h00, 512}};

  // Pulled-up line: either party enabling its driver pulls it low.
  assign line = (serial_out_oe ? serial_out_o : 1'b1) & ~card_oe;

  scu_sim_uart scu_sim_uart_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_clock_pin(ext_clock_pin),
    .serial_in_pin(line), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
    .irq(irq));
  scu_card scu_card_inst (.clk(clk), .line(line), .card_oe(card_oe));

  // ------------------------------------------------------------
  // Clocks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // External bit clock, one rising edge every four cycles, slow enough to synchronise.
  always @(posedge clk) begin
    ext_cnt <= ext_cnt + 2'h1;
    ext_clock_pin <= ext_cnt[1];
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  // Both bus tasks return just after an edge so that checks see settled outputs.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_irq(input int lim);
    for (int k = 0; k < lim && irq !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(irq, 1, "interrupt");
  endtask

  // Watchdog sized at about twice the expected run of some 22000 cycles.
  initial begin
    #450000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, addr, wdata} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(rdata, 0, "read data in reset");
    chk({irq, serial_out_oe}, 0, "outputs in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(SCU_OFF_MODE, v);
    chk(v, 32'h08, "mode reset");
    bus_rd(SCU_OFF_BAUD, v);
    chk(v, 0, "divisor reset");
    bus_rd(SCU_OFF_IRQ_MASK, v);
    chk(v, 0, "mask reset");
    bus_rd(8'h20, v);
    chk(v, 0, "unmapped read");
    bus_wr(SCU_OFF_CTRL, 32'hFF);
    bus_rd(SCU_OFF_CTRL, v);
    chk(v[3:0], 4'hF, "control with empty flag");
    bus_wr(SCU_OFF_CTRL, 32'h0);
    // A frozen block ignores strobes.
    @(posedge clk);
    ce <= 1'b0;
    bus_wr(SCU_OFF_BAUD, 32'h55);
    @(posedge clk);
    ce <= 1'b1;
    bus_rd(SCU_OFF_BAUD, v);
    chk(v, 0, "write while frozen");

    // Ordinary traffic, receive then transmit, in direct and inverse formats and at every prescaler setting.
    foreach (rows[i]) begin
      mode = {2'b00, rows[i].inv, rows[i].inv, ~rows[i].inv, rows[i].pre, 1'b0};
      scu_card_inst.bit_clks = rows[i].bits;
      bus_wr(SCU_OFF_BAUD, {24'h0, rows[i].n});
      bus_wr(SCU_OFF_MODE, {24'h0, mode});
      bus_wr(SCU_OFF_CTRL, 32'h2);
      bus_wr(SCU_OFF_IRQ_MASK, 32'h2);
      scu_card_inst.send(rows[i].d, rows[i].inv, 1'b0, 1'b0);
      wait_irq(2000);
      bus_rd(SCU_OFF_RXBUF, v);
      chk(v, {24'h0, rows[i].d}, "received word");
      bus_wr(SCU_OFF_IRQ_STAT, 32'h7);
      bus_wr(SCU_OFF_CTRL, 32'h5);
      bus_wr(SCU_OFF_IRQ_MASK, 32'h1);
      fork
        scu_card_inst.recv(got, rows[i].inv, 1'b0);
        bus_wr(SCU_OFF_TXBUF, {24'h0, rows[i].d});
      join
      chk(irq, 0, "tx irq before stop");
      wait_irq(2000);
      chk(got, rows[i].d, "card byte");
      bus_rd(SCU_OFF_CTRL, v);
      chk(v[4], 1, "shifter idle at irq");
      bus_wr(SCU_OFF_IRQ_STAT, 32'h7);
    end

    // Parity error on receive; read quickly so the error drive is not seen as a start.
    scu_card_inst.bit_clks = 64;
    bus_wr(SCU_OFF_BAUD, 32'h3);
    bus_wr(SCU_OFF_MODE, 32'h08);
    bus_wr(SCU_OFF_CTRL, 32'h2);
    bus_wr(SCU_OFF_IRQ_MASK, 32'h4);
    fork
      scu_card_inst.send(8'h5A, 1'b0, 1'b1, 1'b0);
      begin
        wait_irq(2000);
        chk(serial_out_oe, 1, "error drive");
        bus_rd(SCU_OFF_RXBUF, v);
        chk(v, 32'hC05A, "parity flags");
        @(posedge clk);
        #1;
        chk(serial_out_oe, 0, "drive released");
      end
    join
    bus_wr(SCU_OFF_IRQ_STAT, 32'h7);
    scu_card_inst.send(8'h33, 1'b0, 1'b0, 1'b1);
    wait_irq(10);
    bus_rd(SCU_OFF_RXBUF, v);
    chk(v, 32'hA033, "framing flags");

    // Overrun: second character while the first is unread.
    bus_wr(SCU_OFF_IRQ_STAT, 32'h7);
    scu_card_inst.send(8'h11, 1'b0, 1'b0, 1'b0);
    bus_wr(SCU_OFF_IRQ_STAT, 32'h7);
    scu_card_inst.send(8'h22, 1'b0, 1'b0, 1'b0);
    bus_wr(SCU_OFF_IRQ_MASK, 32'h0);
    chk(irq, 0, "masked");
    bus_rd(SCU_OFF_IRQ_STAT, v);
    chk(v, 32'h4, "status after overrun");
    bus_wr(SCU_OFF_IRQ_MASK, 32'h4);
    chk(irq, 1, "unmasked");
    bus_rd(SCU_OFF_RXBUF, v);
    chk(v[15:12], 4'h9, "overrun flags");
    bus_wr(SCU_OFF_IRQ_STAT, 32'h4);
    chk(irq, 0, "cleared");

    // Transmit held off, then card refuses the character.
    bus_wr(SCU_OFF_CTRL, 32'h4);
    bus_wr(SCU_OFF_IRQ_MASK, 32'h1);
    bus_wr(SCU_OFF_TXBUF, 32'h96);
    repeat (200) @(posedge clk);
    #1;
    chk(line, 1, "no start while disabled");
    bus_rd(SCU_OFF_CTRL, v);
    chk(v[3], 0, "buffer still full");
    fork
      scu_card_inst.recv(got, 1'b0, 1'b1);
      begin
        bus_wr(SCU_OFF_CTRL, 32'h5);
        wait_irq(3000);
        bus_rd(SCU_OFF_LINE, v);
        chk(v[0], 0, "card error seen at irq");
      end
    join
    chk(got, 8'h96, "refused byte");
    bus_wr(SCU_OFF_IRQ_STAT, 32'h7);

    // External bit clock: 16 rising pin edges per bit, four clocks apart.
    bus_wr(SCU_OFF_BAUD, 32'h0);
    // Source select 0 here: the interrupt comes when the shifter loads.
    bus_wr(SCU_OFF_MODE, 32'h09);
    bus_wr(SCU_OFF_CTRL, 32'h1);
    fork
      scu_card_inst.recv(got, 1'b0, 1'b0);
      begin
        bus_wr(SCU_OFF_TXBUF, 32'hC3);
        wait_irq(20);
        bus_rd(SCU_OFF_CTRL, v);
        chk(v[4], 0, "shifter busy at load irq");
      end
    join
    chk(got, 8'hC3, "external clock byte");
    end_sim();
  end
endmodule
